// file: design/supervisor_pkg.sv
// Constants and carrier types shared by the supervisor watchdog design.
// Assumes a single 100 MHz clock and digital comparator results as inputs.
//
// Overview of operation
// - Kick edge every 1.6s, else watchdog output low
// - Reset or kick edge clears watchdog counter
// - After timeout hold low until next kick edge
// - Undervoltage forces watchdog low, released without stretch
// - Floating kick suspends watchdog only in disable variant
// - Active-low reset held, then stretched 200ms
// - Active-high reset high during undervoltage or manual reset
// - Manual reset low starts a full reset pulse
// - Power-fail flag low while sense below reference
// - Watchdog counter held zero during reset
// - Undervoltage reappearing restarts full 200ms stretch
// - Floating disable only while watchdog not timed out
package supervisor_pkg;

    localparam int unsigned CLK_HZ        = 100_000_000;
    localparam int unsigned WDOG_MS       = 1600;
    localparam int unsigned STRETCH_MS    = 200;
    localparam int unsigned WDOG_CYCLES   = (CLK_HZ / 1000) * WDOG_MS;
    localparam int unsigned STRETCH_CYCLES = (CLK_HZ / 1000) * STRETCH_MS;
    localparam int unsigned CNT_W         = 32;
    localparam logic        OUT_RST_VAL   = 1'b0;

    typedef struct packed {
        logic undervoltage;
        logic manual_reset_n;
        logic watchdog_kick_in;
        logic kick_floating;
        logic power_fail_sense;
    } sense_s;

    typedef struct packed {
        logic reset_n;
        logic reset;
        logic watchdog_expired_n;
        logic power_fail_flag_n;
    } supv_out_s;

    typedef enum logic [1:0] {
        ST_HOLD    = 2'b01,
        ST_STRETCH = 2'b10
    } rst_state_e;

endpackage : supervisor_pkg

// file: design/input_sync.sv
// Two-flop synchroniser for a bus of asynchronous pin levels.
// Assumes the inputs are levels from outside the clock domain.
`timescale 1ns/1ps
module input_sync #(
    parameter int unsigned W = 5
) (
    // Clock and reset
    input  wire logic         mclk_in,
    input  wire logic         rst_in,
    // Levels
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_r;

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            meta_r   <= '0;
            sync_out <= '0;
        end else begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule : input_sync

// file: design/supply_supervisor_watchdog.sv
// Supervisor: reset outputs with stretch, watchdog, power-fail flag.
// Assumes comparator results arrive as digital levels from the analog front end.
`timescale 1ns/1ps
module supply_supervisor_watchdog #(
    parameter int unsigned WDOG_LIMIT    = supervisor_pkg::WDOG_CYCLES,
    parameter int unsigned STRETCH_LIMIT = supervisor_pkg::STRETCH_CYCLES,
    parameter bit          HAS_DISABLE   = 1'b0
) (
    // Clock and reset
    input  wire logic mclk_in,
    input  wire logic rst_in,
    // Pin-side inputs
    input  wire logic undervoltage_in,
    input  wire logic manual_reset_n_in,
    input  wire logic watchdog_kick_in,
    input  wire logic kick_floating_in,
    input  wire logic power_fail_sense_in,
    // Outputs
    output logic      reset_n_out,
    output logic      reset_out,
    output logic      watchdog_expired_n_out,
    output logic      power_fail_flag_n_out
);
    supervisor_pkg::sense_s    raw;
    supervisor_pkg::sense_s    s;
    supervisor_pkg::rst_state_e state_r;
    logic [supervisor_pkg::CNT_W-1:0] stretch_r;
    logic [supervisor_pkg::CNT_W-1:0] wdog_r;
    logic kick_prev_r;
    logic expired_r;
    logic disabled_r;
    logic kick_edge;
    logic rst_cond;
    logic in_reset;

    assign raw = '{undervoltage: undervoltage_in, manual_reset_n: manual_reset_n_in,
                   watchdog_kick_in: watchdog_kick_in, kick_floating: kick_floating_in,
                   power_fail_sense: power_fail_sense_in};

    input_sync #(.W(5)) u_sync (
        .mclk_in (mclk_in),
        .rst_in  (rst_in),
        .async_in(raw),
        .sync_out(s)
    );

    ////////////////////////////////////////////////////////////////////////
    // Reset generator.
    assign rst_cond = s.undervoltage | ~s.manual_reset_n;

    // Stretch restarts on every reappearance, so glitches extend the pulse.
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            state_r   <= supervisor_pkg::ST_HOLD;
            stretch_r <= '0;
        end else begin
            unique case (state_r)
                supervisor_pkg::ST_HOLD: begin
                    // A saturated count marks a finished pulse, so the machine rests here until a new condition.
                    if (rst_cond) begin
                        stretch_r <= '0;
                    end else if (stretch_r != '1) begin
                        state_r <= supervisor_pkg::ST_STRETCH;
                    end
                end
                supervisor_pkg::ST_STRETCH: begin
                    if (rst_cond) begin
                        state_r   <= supervisor_pkg::ST_HOLD;
                        stretch_r <= '0;
                    end else if (stretch_r == STRETCH_LIMIT - 1) begin
                        state_r <= supervisor_pkg::ST_HOLD;
                        stretch_r <= '1;
                    end else if (stretch_r != '1) begin
                        stretch_r <= stretch_r + 1'b1;
                    end
                end
            endcase
        end
    end

    // Done flag is the saturated counter value; leaving it requires rst_cond.
    assign in_reset = !(state_r == supervisor_pkg::ST_HOLD && stretch_r == '1 && !rst_cond)
                      ? 1'b1 : 1'b0;

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            reset_n_out <= supervisor_pkg::OUT_RST_VAL;
            reset_out   <= ~supervisor_pkg::OUT_RST_VAL;
        end else begin
            reset_n_out <= ~in_reset;
            reset_out   <= in_reset;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Watchdog.
    assign kick_edge = s.watchdog_kick_in ^ kick_prev_r;

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            kick_prev_r <= 1'b0;
        end else begin
            kick_prev_r <= s.watchdog_kick_in;
        end
    end

    // Disable latches in only while expired_r is clear.
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            disabled_r <= 1'b0;
        end else if (!HAS_DISABLE) begin
            disabled_r <= 1'b0;
        end else if (!s.kick_floating) begin
            disabled_r <= 1'b0;
        end else if (!expired_r) begin
            disabled_r <= 1'b1;
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            wdog_r <= '0;
        end else if (in_reset || kick_edge || disabled_r) begin
            wdog_r <= '0;
        end else if (wdog_r != WDOG_LIMIT - 1) begin
            wdog_r <= wdog_r + 1'b1;
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            expired_r <= 1'b0;
        end else if (kick_edge) begin
            expired_r <= 1'b0;
        end else if (!in_reset && !disabled_r && wdog_r == WDOG_LIMIT - 1) begin
            expired_r <= 1'b1;
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            watchdog_expired_n_out <= supervisor_pkg::OUT_RST_VAL;
            power_fail_flag_n_out  <= supervisor_pkg::OUT_RST_VAL;
        end else begin
            watchdog_expired_n_out <= ~(expired_r | s.undervoltage);
            power_fail_flag_n_out  <= s.power_fail_sense;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions.
    sequence s_cond_gone;
        !rst_cond ##1 !rst_cond;
    endsequence

    property p_rst_hold;
        @(posedge mclk_in) disable iff (rst_in) rst_cond |=> !reset_n_out;
    endproperty
    a_rst_hold: assert property (p_rst_hold) else $error("reset released during condition");

    property p_complement;
        @(posedge mclk_in) disable iff (rst_in) reset_out == !reset_n_out;
    endproperty
    a_complement: assert property (p_complement) else $error("reset outputs not complementary");

    property p_stretch_min;
        @(posedge mclk_in) disable iff (rst_in) $fell(rst_cond) ##0 s_cond_gone |=> !reset_n_out;
    endproperty
    a_stretch_min: assert property (p_stretch_min) else $error("reset released with no stretch");

    property p_manual;
        @(posedge mclk_in) disable iff (rst_in) !s.manual_reset_n |=> reset_out;
    endproperty
    a_manual: assert property (p_manual) else $error("manual reset ignored");

    property p_uv_wdo;
        @(posedge mclk_in) disable iff (rst_in) s.undervoltage |=> !watchdog_expired_n_out;
    endproperty
    a_uv_wdo: assert property (p_uv_wdo) else $error("watchdog output high in undervoltage");

    property p_count_zero;
        @(posedge mclk_in) disable iff (rst_in) (in_reset || kick_edge) |=> wdog_r == '0;
    endproperty
    a_count_zero: assert property (p_count_zero) else $error("watchdog counter not cleared");

    property p_expire_hold;
        @(posedge mclk_in) disable iff (rst_in) expired_r && !kick_edge |=> expired_r;
    endproperty
    a_expire_hold: assert property (p_expire_hold) else $error("timeout released without kick");

    property p_pf;
        @(posedge mclk_in) disable iff (rst_in) ##1 power_fail_flag_n_out == $past(s.power_fail_sense);
    endproperty
    a_pf: assert property (p_pf) else $error("power-fail flag mismatch");

    property p_no_disable;
        @(posedge mclk_in) disable iff (rst_in) (!HAS_DISABLE || expired_r) |=> !$rose(disabled_r);
    endproperty
    a_no_disable: assert property (p_no_disable) else $error("illegal watchdog disable");

endmodule : supply_supervisor_watchdog

// file: bench/micro_host_model.sv
// Model of the supervised processor: toggles the watchdog kick while running.
// Assumes the supervisor's active-low reset drives it and the bench sets the kick period.
`timescale 1ns/1ps
module micro_host_model (
    // Clock
    input  wire logic        mclk_in,
    // Control
    input  wire logic        reset_n_in,
    input  wire logic        kick_en_in,
    input  wire logic [15:0] period_in,
    // Kick pin
    output logic             kick_out
);
    logic [15:0] cnt_r;

    initial begin
        kick_out = 1'b0;
        cnt_r    = 16'h0;
    end

    ////////////////////////////////////////////////////////////////
    // Firmware is halted in reset, so no kicks arrive while it is held.
    always @(posedge mclk_in) begin
        if (!reset_n_in || !kick_en_in) begin
            cnt_r <= 16'h0;
        end else if (cnt_r >= period_in - 16'h1) begin
            cnt_r    <= 16'h0;
            kick_out <= ~kick_out;
        end else begin
            cnt_r <= cnt_r + 16'h1;
        end
    end
endmodule : micro_host_model

// file: bench/tb.sv
// Self-checking bench for the supervisor with shortened intervals.
// Assumes the disable variant so that the floating-kick path is reachable.
`timescale 1ns/1ps
module tb;
    localparam int WD = 200;
    localparam int ST = 50;
    logic mclk_in, rst_in, uv, mr_n, flt, sense, kick_en, kick, rn, ra, wd, pf;
    logic [15:0] period;
    logic [31:0] seed;
    int miscompares, samples_checked, len;
    supervisor_pkg::supv_out_s o;

    assign o = {rn, ra, wd, pf};

    supply_supervisor_watchdog #(.WDOG_LIMIT(WD), .STRETCH_LIMIT(ST), .HAS_DISABLE(1'b1))
        supply_supervisor_watchdog_i (.mclk_in(mclk_in), .rst_in(rst_in), .undervoltage_in(uv),
        .manual_reset_n_in(mr_n), .watchdog_kick_in(kick), .kick_floating_in(flt),
        .power_fail_sense_in(sense), .reset_n_out(rn), .reset_out(ra),
        .watchdog_expired_n_out(wd), .power_fail_flag_n_out(pf));

    micro_host_model micro_host_model_i (.mclk_in(mclk_in), .reset_n_in(rn), .kick_en_in(kick_en),
        .period_in(period), .kick_out(kick));

    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    task automatic cyc(int n);
        repeat (n) @(posedge mclk_in);
        #1;
    endtask : cyc

    task automatic chk(string nm, logic e, logic g);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %b seen %b", nm, e, g);
        end
    endtask : chk

    // Output bit b must reach v no sooner than lo and no later than hi cycles.
    task automatic settle(string nm, int b, logic v, int lo, int hi);
        int n;
        for (n = 0; n < hi && o[b] !== v; n++) cyc(1);
        samples_checked++;
        if (n < lo || o[b] !== v) begin
            miscompares++;
            $display("mismatch %s expected %b in %0d..%0d seen %b at %0d", nm, v, lo, hi, o[b], n);
        end
    endtask : settle

    task automatic test_done();
        if (miscompares == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : test_done

    ////////////////////////////////////////////////////////////////
    initial begin
        mclk_in = 1'b0;
        forever #5 mclk_in = ~mclk_in;
    end

    // The scenarios need about 6,500 cycles; the limit allows roughly five times that.
    initial begin
        #300_000;
        miscompares++;
        test_done();
    end

    initial begin
        {rst_in, uv, mr_n, flt, sense, kick_en} = 6'b101011;
        period = 16'd50;
        seed = 32'hd83a;
        cyc(2);
        chk("reset_n", 1'b0, rn);
        chk("reset", 1'b1, ra);
        rst_in = 1'b0;
        settle("reset_n", 3, 1'b1, ST - 5, ST + 10);
        chk("reset", 1'b0, ra);
        repeat (20) begin
            sense = 1'(xs());
            settle("pf_flag_n", 0, sense, 0, 5);
        end
        repeat (6) begin
            period = 16'(3 + xs() % (WD - 30));
            cyc(3 * WD);
            chk("wdog_n", 1'b1, wd);
        end
        @(kick);
        cyc(1);
        kick_en = 1'b0;
        settle("wdog_n", 1, 1'b0, WD - 10, WD + 10);
        cyc(2 * WD);
        chk("wdog_n", 1'b0, wd);
        flt = 1'b1;
        cyc(WD);
        chk("wdog_n", 1'b0, wd);
        {flt, kick_en, period} = {2'b01, 16'd20};
        settle("wdog_n", 1, 1'b1, 0, 30);
        {flt, kick_en} = 2'b10;
        cyc(3 * WD);
        chk("wdog_n", 1'b1, wd);
        {flt, kick_en} = 2'b01;
        len = 3 * WD + (xs() & 31);
        mr_n = 1'b0;
        settle("reset_n", 3, 1'b0, 2, 5);
        cyc(len);
        chk("reset", 1'b1, ra);
        chk("wdog_n", 1'b1, wd);
        mr_n = 1'b1;
        settle("reset_n", 3, 1'b1, ST - 5, ST + 10);
        chk("reset", 1'b0, ra);
        uv = 1'b1;
        settle("wdog_n", 1, 1'b0, 2, 5);
        chk("reset", 1'b1, ra);
        cyc(10);
        uv = 1'b0;
        settle("wdog_n", 1, 1'b1, 2, 6);
        chk("reset_n", 1'b0, rn);
        cyc(20);
        uv = 1'b1;
        cyc(5);
        uv = 1'b0;
        settle("reset_n", 3, 1'b1, ST - 5, ST + 12);
        test_done();
    end
endmodule : tb
